/* design/repeater_config_consts.vh */
`ifndef REPEATER_CONFIG_CONSTS_VH
`define REPEATER_CONFIG_CONSTS_VH

// Register offsets.
`define RCR_ID_OFFSET        8'h00
`define RCR_CTRL1_OFFSET     8'h01
`define RCR_CTRL2_OFFSET     8'h02

// Reset values.
`define RCR_ID_RESET         8'h00
`define RCR_CTRL1_RESET      8'h00
`define RCR_CTRL2_RESET      8'h00

// Identification register fields.
`define RCR_ID_RSVD_BIT      7
`define RCR_ID_STRAP_MSB     6
`define RCR_ID_STRAP_LSB     3
`define RCR_ID_LOADING_BIT   2

// First control register fields.
`define RCR_CTRL1_TALK_A_BIT 7
`define RCR_CTRL1_TALK_B_BIT 6
`define RCR_CTRL1_LOS_SEL_BIT 2

// The strap capture waits this many edges after reset release.
`define RCR_STRAP_CAPTURE_CNT 2'h2

// Second control register fields.
`define RCR_CTRL2_OVR_EN_BIT  5
`define RCR_CTRL2_OVR_LVL_BIT 4

`endif

/* design/repeater_config_registers.v */
// Contract
// - ID bits 6:3 return sampled strap address.
// - ID bit 2 high while EEPROM loads.
// - Control1 bits 7:6 enable continuous talk A/B.
// - Control1 bit 2 picks channel B signal-loss.
// - Control2 bit 5 makes pin follow override.
// - Override level 1 normal, 0 asserts loss.
`timescale 1ns/1ns
`default_nettype none
`include "repeater_config_consts.vh"

module repeater_config_registers (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       reg_wr_en,
    input  wire       reg_rd_en,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       eeprom_loading,
    input  wire       eeprom_wr_en,
    input  wire [7:0] eeprom_addr,
    input  wire [7:0] eeprom_wdata,
    input  wire [3:0] strap_addr,
    input  wire       loss_detect_a,
    input  wire       loss_detect_b,
    output reg        continuous_talk_a,
    output reg        continuous_talk_b,
    output reg        signal_loss_out
);

    // Synchronisers, stored fields and the shared write and read paths.
    reg  [3:0] strap_meta_q;
    reg  [3:0] strap_sync_q;
    reg  [3:0] strap_q;
    reg  [1:0] strap_cnt_q;
    wire [1:0] loss_raw;
    wire [1:0] loss_sync;
    reg        id_rsvd_q;
    reg  [7:0] ctrl1_q;
    reg  [7:0] ctrl2_q;
    reg  [7:0] rdata_d;
    reg        loss_d;
    wire       wr_en;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire       signal_loss_source_select;
    wire       signal_loss_pin_override_enable;
    wire       signal_loss_override_level;
    genvar     ch;

    // Strap pins come from outside the clock domain; two flops first.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta_q <= 4'h0;
            strap_sync_q <= 4'h0;
        end
        else
        begin
            strap_meta_q <= strap_addr;
            strap_sync_q <= strap_meta_q;
        end
    end

    // Each channel's detector crosses in through its own two flops.
    assign loss_raw = {loss_detect_b, loss_detect_a};
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_loss_sync
            reg meta_q;
            reg sync_q;
            always @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= loss_raw[ch];
                    sync_q <= meta_q;
                end
            end
            assign loss_sync[ch] = sync_q;
        end
    endgenerate

    // The strap is taken once, at the third edge after reset release,
    // when the synchroniser finally holds the pin value. Taking it any
    // earlier would latch the reset zeros of the synchroniser instead.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_q     <= 4'h0;
            strap_cnt_q <= 2'h0;
        end
        else if (strap_cnt_q != 2'h3)
        begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `RCR_STRAP_CAPTURE_CNT)
            begin
                strap_q <= strap_sync_q;
            end
        end
    end

    // The EEPROM loader owns the register write port while it writes.
    // A host write that lands in the same cycle is dropped, so the host
    // must not write while the loading flag is still set.
    assign wr_en   = eeprom_wr_en | reg_wr_en;
    assign wr_addr = eeprom_wr_en ? eeprom_addr : reg_addr;
    assign wr_data = eeprom_wr_en ? eeprom_wdata : reg_wdata;

    // Writable register storage; self-clearing ID bits 1:0 keep nothing.
    // Writes to offsets outside the bank are ignored.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            id_rsvd_q <= 1'b0;
            ctrl1_q   <= `RCR_CTRL1_RESET;
            ctrl2_q   <= `RCR_CTRL2_RESET;
        end
        else if (wr_en)
        begin
            if (wr_addr == `RCR_ID_OFFSET)
            begin
                id_rsvd_q <= wr_data[`RCR_ID_RSVD_BIT];
            end
            else if (wr_addr == `RCR_CTRL1_OFFSET)
            begin
                ctrl1_q <= wr_data;
            end
            else if (wr_addr == `RCR_CTRL2_OFFSET)
            begin
                ctrl2_q <= wr_data;
            end
        end
    end

    // Named views of the control fields that steer the loss pin.
    assign signal_loss_source_select =
        ctrl1_q[`RCR_CTRL1_LOS_SEL_BIT];
    assign signal_loss_pin_override_enable =
        ctrl2_q[`RCR_CTRL2_OVR_EN_BIT];
    assign signal_loss_override_level =
        ctrl2_q[`RCR_CTRL2_OVR_LVL_BIT];

    // Read mux; unmapped offsets read as zero.
    // The loading flag is read straight from the loader, which runs on
    // this clock, so it needs no synchroniser.
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_addr == `RCR_ID_OFFSET)
        begin
            rdata_d[`RCR_ID_RSVD_BIT] = id_rsvd_q;
            rdata_d[`RCR_ID_STRAP_MSB:`RCR_ID_STRAP_LSB] =
                strap_q;
            rdata_d[`RCR_ID_LOADING_BIT] = eeprom_loading;
        end
        else if (reg_addr == `RCR_CTRL1_OFFSET)
        begin
            rdata_d = ctrl1_q;
        end
        else if (reg_addr == `RCR_CTRL2_OFFSET)
        begin
            rdata_d = ctrl2_q;
        end
    end

    // Pin override replaces detection; level 0 forces a loss indication.
    // Without the override the selected channel's detector is passed on.
    always @*
    begin
        if (signal_loss_pin_override_enable)
        begin
            loss_d = ~signal_loss_override_level;
        end
        else if (signal_loss_source_select)
        begin
            loss_d = loss_sync[1];
        end
        else
        begin
            loss_d = loss_sync[0];
        end
    end

    // Output flops for read data and the control outputs.
    // Read data is loaded only on a read strobe and holds until the next.
    // The loss pin lags its detector by three edges in all.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata         <= 8'h00;
            continuous_talk_a <= 1'b0;
            continuous_talk_b <= 1'b0;
            signal_loss_out   <= 1'b0;
        end
        else
        begin
            if (reg_rd_en)
            begin
                reg_rdata <= rdata_d;
            end
            continuous_talk_a <= ctrl1_q[`RCR_CTRL1_TALK_A_BIT];
            continuous_talk_b <= ctrl1_q[`RCR_CTRL1_TALK_B_BIT];
            signal_loss_out   <= loss_d;
        end
    end

endmodule // repeater_config_registers

`default_nettype wire

/* sim/repeater_config_registers_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module repeater_config_registers_asserts (
    input wire logic core_clk, rst, reg_wr_en, reg_rd_en, eeprom_wr_en,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [7:0] eeprom_addr, eeprom_wdata,
    input wire logic eeprom_loading, loss_detect_a, loss_detect_b,
    input wire logic [3:0] strap_addr,
    input wire logic continuous_talk_a, continuous_talk_b, signal_loss_out
);
    logic [7:0] wa, wd, c1, c2;
    logic rid;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // The loader write wins, as in the block.
    assign wa = eeprom_wr_en ? eeprom_addr : reg_wr_en ? reg_addr : 8'hff;
    assign wd = eeprom_wr_en ? eeprom_wdata : reg_wdata;
    assign rid = reg_rd_en && reg_addr == 8'h00;
    // Shadow copies of both control registers.
    always @(posedge core_clk or posedge rst)
        if (rst) {c1, c2} <= 16'h0;
        else if (wa == 8'h01) c1 <= wd;
        else if (wa == 8'h02) c2 <= wd;
    a_strap_readback: assert property (
        rid |=> reg_rdata[6:3] == strap_addr)
        else $error("strap field wrong");
    a_load_flag: assert property (
        rid |=> reg_rdata[2] == $past(eeprom_loading))
        else $error("loading flag wrong");
    a_talk_a_follows: assert property (
        wa == 8'h01 |=> ##1 continuous_talk_a == $past(wd[7], 2))
        else $error("talk a wrong");
    a_talk_b_follows: assert property (
        wa == 8'h01 |=> ##1 continuous_talk_b == $past(wd[6], 2))
        else $error("talk b wrong");
    a_loss_source: assert property (
        (!c2[5] && $stable(c1[2])) [*4] |->
        signal_loss_out == $past(c1[2] ? loss_detect_b : loss_detect_a, 3))
        else $error("loss path wrong");
    a_override_level: assert property (
        c2[5] [*2] |-> signal_loss_out == !$past(c2[4]))
        else $error("override level wrong");
    cover property (rid && eeprom_loading);
    cover property (c2[5] && !c2[4]);
    cover property (wa == 8'h01 && wd[7]);
endmodule // repeater_config_registers_asserts
bind repeater_config_registers repeater_config_registers_asserts u_chk (.*);
`default_nettype wire

/* sim/eeprom_loader_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eeprom_loader_model #(
    parameter logic [7:0] HDR = 8'h43,
    parameter logic [7:0] IMG1 = 8'h84,
    parameter logic [7:0] IMG2 = 8'h30
) (
    input wire logic core_clk, rst, go,
    output logic loading, wr_en,
    output logic [7:0] addr, wdata
);
    logic [2:0] n_q;
    // Walks the image one byte a cycle once started.
    always @(posedge core_clk or posedge rst)
        if (rst) n_q <= 3'd0;
        else if (go || n_q != 3'd0) n_q <= (n_q == 3'd4) ? 3'd0 : n_q + 3'd1;
    // Offset 3 opens the shared block, which this bank does not map.
    assign loading = n_q != 3'd0;
    assign wr_en = n_q > 3'd1;
    assign addr = {5'h0, n_q} - 8'h01;
    // Step 1 fetches the image's header byte (flags and device count);
    // it is never written into the bank, since wr_en stays low then.
    assign wdata = n_q == 3'd1 ? HDR : n_q == 3'd2 ? IMG1 :
                   n_q == 3'd3 ? IMG2 : 8'h55;
endmodule // eeprom_loader_model
`default_nettype wire

/* sim/tb_repeater_config_registers.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_repeater_config_registers;
    logic core_clk = 0, rst = 1, we = 0, re = 0, go = 0, la = 0, lb = 0;
    logic el, ew, ta, tb_, lo;
    logic [7:0] ad = 0, wd = 0, rd, ea, ed, c1 = 8'h84, c2 = 8'h30, k, d;
    logic [7:0] mk [4] = '{8'h00, 8'hc4, 8'h30, 8'hff};
    logic [3:0] st = 4'ha;
    int bad_count = 0, compares = 0, i;
    integer seed = 46;
    always #25 core_clk = ~core_clk;
    eeprom_loader_model u_eeprom_loader_model (.core_clk(core_clk),
        .rst(rst), .go(go), .loading(el), .wr_en(ew), .addr(ea), .wdata(ed));
    repeater_config_registers u_repeater_config_registers (
        .core_clk(core_clk), .rst(rst), .reg_wr_en(we), .reg_rd_en(re),
        .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rd), .eeprom_loading(el),
        .eeprom_wr_en(ew), .eeprom_addr(ea), .eeprom_wdata(ed),
        .strap_addr(st), .loss_detect_a(la), .loss_detect_b(lb),
        .continuous_talk_a(ta), .continuous_talk_b(tb_),
        .signal_loss_out(lo));
    task chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task cyc(input logic w, r, input logic [7:0] a, v);
        @(posedge core_clk);
        we <= w; re <= r; ad <= a; wd <= v;
        @(posedge core_clk);
        we <= 0; re <= 0;
    endtask
    task rdc(input logic [7:0] a, e);
        cyc(0, 1, a, 8'h00);
        @(negedge core_clk);
        chk("rdata", rd, e);
    endtask
    // Expected loss pin from the bench's control bytes and detectors.
    function automatic logic [7:0] exp_loss();
        if (c2[5]) return {7'h0, !c2[4]};
        return {7'h0, c1[2] ? lb : la};
    endfunction
    task test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Loader fill, then random host traffic against a bench model.
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        repeat (4) @(posedge core_clk);
        go <= 1;
        @(posedge core_clk);
        go <= 0;
        rdc(8'h00, {1'b0, st, 3'b100});
        repeat (4) @(posedge core_clk);
        rdc(8'h00, {1'b0, st, 3'b000});
        rdc(8'h01, c1);
        rdc(8'h02, c2);
        rdc(8'h03, 8'h00);
        for (i = 0; i < 60; i++)
        begin
            k = $random(seed);
            d = $random(seed) & mk[k[1:0]];
            cyc(1, 0, {6'h0, k[1:0]}, d);
            if (k[1:0] == 2'd1) c1 = d;
            if (k[1:0] == 2'd2) c2 = d;
            la <= k[2];
            lb <= k[3];
            repeat (5) @(negedge core_clk);
            chk("talk", {6'h0, ta, tb_}, {6'h0, c1[7:6]});
            chk("loss", {7'h0, lo}, exp_loss());
        end
        rdc(8'h01, c1);
        rdc(8'h02, c2);
        // Mid-run reset: outputs clear, a new strap is taken afresh.
        rst <= 1;
        la <= 0;
        lb <= 0;
        st <= 4'h5;
        repeat (2) @(negedge core_clk);
        chk("rst_out", {5'h0, ta, tb_, lo}, 8'h00);
        chk("rst_rdata", rd, 8'h00);
        @(posedge core_clk);
        rst <= 0;
        c1 = 8'h00;
        c2 = 8'h00;
        repeat (4) @(posedge core_clk);
        rdc(8'h00, {1'b0, st, 3'b000});
        rdc(8'h01, c1);
        rdc(8'h02, c2);
        test_done;
    end
endmodule // tb_repeater_config_registers
`default_nettype wire
